// ---- src/lcdc_decoder.sv ----
// Display driver command decoder with its display RAM and write buffer.
//
// Functional notes
// [RQ1] Command 101110xx loads the two-bit page pointer.
// [RQ2] Page changes move only host access, never the shown image.
// [RQ3] Command with bit 7 clear loads the column pointer, valid 0 to 79.
// [RQ4] Each display RAM access advances the column pointer by one.
// [RQ5] Column advance stops at 80; page never advances by itself.
// [RQ6] Command-side read returns busy, direction, off, reset flags, low nibble zero.
// [RQ7] Busy reads 1 while executing or resetting; commands then are ignored.
// [RQ8] Direction flag 1 means column n to segment n, 0 means 79 minus u.
// [RQ9] Off flag is the inverse of the last display on/off bit.
// [RQ10] Reset flag reads 1 while hardware or software reset executes.
// [RQ11] Data write stores the byte at page and column, then advances column.
// [RQ12] Data read returns latch, refills latch from RAM, then advances column.
// [RQ13] Host discards one data read after setting a new column.
// [RQ14] Direction command bit 1 drives first segment from column 4F, 0 from 00.
// [RQ15] Static drive bit 1 forces display on with all commons selected.
// [RQ16] Duty command low bit sets drive duty; host picks the 1/32 value.
// [RQ17] Read-modify-write saves column, stops advance after reads, not after writes.
// [RQ18] Read-modify-write lasts until end command; other commands still work.
// [RQ19] Host issues no column set while read-modify-write is active.
// [RQ20] End command leaves the mode and restores the saved column.
// [RQ21] Software reset clears start line, sets page 3, keeps RAM contents.
// [RQ22] Host asserts hardware reset at power-up; software reset cannot replace it.
// [RQ23] Display on/off command turns panel on with bit 1, off with bit 0.
// [RQ24] Start line command loads five low bits, line 0 to 31 at first common.
// [RQ25] Register select and direction tell command, status and data apart.
// [RQ26] Transfers are taken on the falling edge of the enable strobe.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Write buffer between the host port and the display RAM.
module lcdc_fifo
   import lcdc_pkg::*;
#(
   parameter int WIDTH = WQ_WIDTH,
   parameter int DEPTH = WQ_DEPTH
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wptr;
      logic [AW:0] rptr;
   } lcdc_fifo_state_t;

   lcdc_fifo_state_t st;
   lcdc_fifo_state_t next_st;
   logic [AW:0] count;

   assign count = st.wptr - st.rptr;
   assign in_ready = (count != FULL_COUNT);
   assign out_valid = (count != '0);
   assign out_data = st.mem[st.rptr[AW-1:0]];

   always_comb begin
      next_st = st;
      if (in_valid && in_ready) begin
         next_st.mem[st.wptr[AW-1:0]] = in_data;
         next_st.wptr = st.wptr + 1'b1;
      end
      if (out_valid && out_ready) begin
         next_st.rptr = st.rptr + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Command decoder top.
module lcdc_decoder
   import lcdc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire lcdc_host_pins_t host,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   input wire logic scan_req,
   input wire logic [1:0] scan_page,
   input wire logic [6:0] scan_col,
   output logic [7:0] scan_data,
   output lcdc_panel_t panel
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.
   function automatic logic [8:0] ram_index(input logic [1:0] page, input logic [6:0] col);
      ram_index = 9'(9'(page) * COLS_PER_PAGE + 9'(col));
   endfunction

   function automatic logic [6:0] col_advance(input logic [6:0] col);
      col_advance = (col >= COL_LIMIT) ? col : 7'(col + 7'h01);
   endfunction

   function automatic lcdc_op_t decode_op(input logic [7:0] b);
      if (!b[7]) begin
         decode_op = LCDC_OP_COL;
      end else if ((b & MASK_LOW2) == CMD_PAGE) begin
         decode_op = LCDC_OP_PAGE;
      end else if ((b & MASK_LOW5) == CMD_START) begin
         decode_op = LCDC_OP_START;
      end else if ((b & MASK_LOW1) == CMD_DISP) begin
         decode_op = LCDC_OP_DISP;
      end else if ((b & MASK_LOW1) == CMD_SEG) begin
         decode_op = LCDC_OP_SEG;
      end else if ((b & MASK_LOW1) == CMD_STATIC) begin
         decode_op = LCDC_OP_STATIC;
      end else if ((b & MASK_LOW1) == CMD_DUTY) begin
         decode_op = LCDC_OP_DUTY;
      end else if (b == CMD_RMW) begin
         decode_op = LCDC_OP_RMW;
      end else if (b == CMD_END) begin
         decode_op = LCDC_OP_END;
      end else if (b == CMD_SWRST) begin
         decode_op = LCDC_OP_SWRST;
      end else begin
         decode_op = LCDC_OP_NONE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State and buffer.
   lcdc_state_t st;
   lcdc_state_t next_st;
   lcdc_wr_t wq_in;
   lcdc_wr_t wq_out;
   logic wq_push;
   logic wq_ready;
   logic wq_valid;
   logic wq_pop;
   logic fall;
   logic busy;
   logic [7:0] status;

   lcdc_fifo #(
      .WIDTH(WQ_WIDTH),
      .DEPTH(WQ_DEPTH)
   ) u_wq (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .in_data(wq_in),
      .in_valid(wq_push),
      .in_ready(wq_ready),
      .out_data(wq_out),
      .out_valid(wq_valid),
      .out_ready(wq_pop)
   );

   // The panel scan owns the RAM port while it asks, so the buffer drains only in its gaps.
   assign wq_pop = wq_valid && !scan_req;

   // A full buffer or a pending latch refill counts as executing.
   assign busy = (st.mode == LCDC_RESETTING) || !wq_ready || st.refill_pend; // RQ7 RQ10

   always_comb begin
      status = 8'h00;
      status[ST_BUSY] = busy; // RQ6 RQ7
      status[ST_SEG] = !st.seg_rev; // RQ8
      status[ST_OFF] = !st.disp_on; // RQ9
      status[ST_RST] = (st.mode == LCDC_RESETTING); // RQ10
   end

   assign fall = st.enable_q && !host.enable; // RQ26

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      next_st = st;
      wq_push = 1'b0;
      wq_in = '{page: st.page, col: st.col, data: host.data};
      next_st.enable_q = host.enable;

      case (st.mode)
         LCDC_RESETTING: begin
            if (st.rst_cnt == RST_LAST) begin
               next_st.mode = LCDC_READY;
               next_st.rst_cnt = 8'h00;
            end else begin
               next_st.rst_cnt = 8'(st.rst_cnt + 8'h01);
            end
         end
         default: begin
            next_st.rst_cnt = 8'h00;
         end
      endcase

      // Status reads are always answered; everything else is ignored while busy.
      if (fall && !busy && !(host.read_not_write && !host.register_select)) begin // RQ7 RQ25
         if (host.register_select && !host.read_not_write) begin
            wq_push = 1'b1; // RQ11
            next_st.col = col_advance(st.col); // RQ4 RQ5 RQ17
         end else if (host.register_select) begin
            next_st.refill_pend = 1'b1; // RQ12
            next_st.refill_page = st.page;
            next_st.refill_col = st.col;
            if (!st.rmw) begin
               next_st.col = col_advance(st.col); // RQ4 RQ5 RQ17
            end
         end else begin
            case (decode_op(host.data))
               LCDC_OP_PAGE: begin
                  next_st.page = host.data[1:0]; // RQ1 RQ2
               end
               LCDC_OP_COL: begin
                  next_st.col = host.data[6:0]; // RQ3
               end
               LCDC_OP_START: begin
                  next_st.start_line = host.data[4:0]; // RQ24
               end
               LCDC_OP_DISP: begin
                  next_st.disp_on = host.data[0]; // RQ23 RQ9
               end
               LCDC_OP_SEG: begin
                  next_st.seg_rev = host.data[0]; // RQ14
               end
               LCDC_OP_STATIC: begin
                  next_st.static_drv = host.data[0]; // RQ15
               end
               LCDC_OP_DUTY: begin
                  next_st.duty_32 = host.data[0]; // RQ16
               end
               LCDC_OP_RMW: begin
                  next_st.rmw = 1'b1; // RQ17 RQ18
                  next_st.saved_col = st.col;
               end
               LCDC_OP_END: begin
                  if (st.rmw) begin
                     next_st.rmw = 1'b0; // RQ20
                     next_st.col = st.saved_col;
                  end
               end
               LCDC_OP_SWRST: begin
                  next_st.start_line = START_RESET; // RQ21
                  next_st.page = PAGE_RESET;
                  next_st.mode = LCDC_RESETTING; // RQ10
                  next_st.rst_cnt = 8'h00;
               end
               default: begin
               end
            endcase
         end
      end

      // Drain buffered writes; columns past the last one hold nothing.
      if (wq_pop && (wq_out.col < COL_LIMIT)) begin
         next_st.ram[ram_index(wq_out.page, wq_out.col)] = wq_out.data; // RQ11
      end

      // The refill waits for earlier writes so that it sees them.
      if (st.refill_pend && !wq_valid && !scan_req) begin
         next_st.refill_pend = 1'b0; // RQ12
         if (st.refill_col < COL_LIMIT) begin
            next_st.out_latch = st.ram[ram_index(st.refill_page, st.refill_col)];
         end else begin
            next_st.out_latch = 8'h00;
         end
      end

      // A scan past the last column reads as blank, like a host read there.
      if (scan_req && (scan_col < COL_LIMIT)) begin
         next_st.scan_data = st.ram[ram_index(scan_page, scan_col)];
      end else if (scan_req) begin
         next_st.scan_data = 8'h00;
      end

      next_st.data_out = host.register_select ? st.out_latch : status; // RQ6 RQ12 RQ25
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
         st.mode <= LCDC_RESETTING; // RQ10
         st.page <= PAGE_RESET;
         st.col <= COL_RESET;
         st.start_line <= START_RESET;
         st.disp_on <= DISP_ON_RESET;
         st.seg_rev <= SEG_REV_RESET;
         st.static_drv <= STATIC_RESET;
         st.duty_32 <= DUTY_RESET;
         st.rmw <= RMW_RESET;
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign host_data_out = st.data_out;
   assign host_data_oe = host.enable && host.read_not_write;
   assign scan_data = st.scan_data;

   always_comb begin
      panel.display_on = st.disp_on || st.static_drv; // RQ15 RQ23
      panel.seg_reverse = st.seg_rev; // RQ14
      panel.static_drive = st.static_drv;
      panel.all_com_select = st.static_drv; // RQ15
      panel.duty_32 = st.duty_32; // RQ16
      panel.start_line = st.start_line; // RQ24
   end
endmodule

`default_nettype wire

// ---- src/lcdc_pkg.sv ----
// Package with constants, command codes and carrier types of the display command decoder.
package lcdc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_MHZ = 250;
   localparam int RST_TIME_NS = 1000;
   localparam int RST_CYCLES = (RST_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] RST_LAST = 8'(RST_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Display RAM geometry and reset values.
   localparam int RAM_BYTES = 320;
   localparam logic [8:0] COLS_PER_PAGE = 9'h050;
   localparam logic [6:0] COL_LIMIT = 7'h50;
   localparam logic [6:0] COL_RESET = 7'h00;
   localparam logic [1:0] PAGE_RESET = 2'h3;
   localparam logic [4:0] START_RESET = 5'h00;
   localparam logic DISP_ON_RESET = 1'b0;
   localparam logic SEG_REV_RESET = 1'b0;
   localparam logic STATIC_RESET = 1'b0;
   localparam logic DUTY_RESET = 1'b0;
   localparam logic RMW_RESET = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Command patterns and masks.
   localparam logic [7:0] CMD_DISP = 8'hAE;
   localparam logic [7:0] CMD_START = 8'hC0;
   localparam logic [7:0] CMD_PAGE = 8'hB8;
   localparam logic [7:0] CMD_SEG = 8'hA0;
   localparam logic [7:0] CMD_STATIC = 8'hA4;
   localparam logic [7:0] CMD_DUTY = 8'hA8;
   localparam logic [7:0] CMD_RMW = 8'hE0;
   localparam logic [7:0] CMD_END = 8'hEE;
   localparam logic [7:0] CMD_SWRST = 8'hE2;
   localparam logic [7:0] MASK_LOW1 = 8'hFE;
   localparam logic [7:0] MASK_LOW2 = 8'hFC;
   localparam logic [7:0] MASK_LOW5 = 8'hE0;

   ////////////////////////////////////////////////////////////////////////////////
   // Status byte bit positions.
   localparam int ST_BUSY = 7;
   localparam int ST_SEG = 6;
   localparam int ST_OFF = 5;
   localparam int ST_RST = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Buffer geometry.
   localparam int WQ_DEPTH = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum logic [3:0] {
      LCDC_OP_NONE = 4'b0000,
      LCDC_OP_DISP = 4'b0001,
      LCDC_OP_START = 4'b0010,
      LCDC_OP_PAGE = 4'b0011,
      LCDC_OP_COL = 4'b0100,
      LCDC_OP_SEG = 4'b0101,
      LCDC_OP_STATIC = 4'b0110,
      LCDC_OP_DUTY = 4'b0111,
      LCDC_OP_RMW = 4'b1000,
      LCDC_OP_END = 4'b1001,
      LCDC_OP_SWRST = 4'b1010
   } lcdc_op_t;

   typedef enum logic [1:0] {
      LCDC_READY = 2'b00,
      LCDC_RESETTING = 2'b01
   } lcdc_mode_t;

   typedef struct packed {
      logic register_select;
      logic read_not_write;
      logic enable;
      logic [7:0] data;
   } lcdc_host_pins_t;

   typedef struct packed {
      logic [1:0] page;
      logic [6:0] col;
      logic [7:0] data;
   } lcdc_wr_t;

   localparam int WQ_WIDTH = $bits(lcdc_wr_t);

   typedef struct packed {
      logic display_on;
      logic seg_reverse;
      logic static_drive;
      logic all_com_select;
      logic duty_32;
      logic [4:0] start_line;
   } lcdc_panel_t;

   typedef struct packed {
      lcdc_mode_t mode;
      logic [7:0] rst_cnt;
      logic enable_q;
      logic [1:0] page;
      logic [6:0] col;
      logic [6:0] saved_col;
      logic rmw;
      logic disp_on;
      logic seg_rev;
      logic static_drv;
      logic duty_32;
      logic [4:0] start_line;
      logic refill_pend;
      logic [1:0] refill_page;
      logic [6:0] refill_col;
      logic [7:0] out_latch;
      logic [7:0] data_out;
      logic [7:0] scan_data;
      logic [RAM_BYTES-1:0][7:0] ram;
   } lcdc_state_t;

endpackage

// ---- testbench/lcdc_decoder_properties.sv ----
// Concurrent checks on the ports of the display command decoder.
`timescale 1ns/1ps
`default_nettype none
module lcdc_decoder_properties
   import lcdc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire lcdc_host_pins_t host,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe,
   input wire logic scan_req,
   input wire logic [1:0] scan_page,
   input wire logic [6:0] scan_col,
   input wire logic [7:0] scan_data,
   input wire lcdc_panel_t panel
);
   logic en_q;
   logic cmd_go;
   logic rs_lo;
   default clocking dcb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         en_q <= 1'b0;
      end else if (ce) begin
         en_q <= host.enable;
      end
   end
   assign rs_lo = !host.register_select;
   // A command is only counted as taken when the status byte shows the device ready.
   assign cmd_go = ce && en_q && !host.enable && rs_lo && !host.read_not_write
      && !host_data_out[7];
   ////////////////////////////////////////
   oe_follow_a: assert property (host_data_oe == (host.enable && host.read_not_write))
      else $error("Bus drive enable does not follow a read strobe.");
   status_nibble_a: assert property (rs_lo [*2] |-> host_data_out[3:0] == 4'h0)
      else $error("Status low nibble is not zero.");
   reset_busy_a: assert property (rs_lo [*2] ##0 host_data_out[4] |-> host_data_out[7])
      else $error("Reset flag set without busy flag.");
   off_flag_a: assert property ((rs_lo && !panel.static_drive && $stable(panel.display_on)) [*3]
      |-> host_data_out[5] == !panel.display_on) else $error("Display off flag is wrong.");
   seg_flag_a: assert property ((rs_lo && $stable(panel.seg_reverse)) [*3]
      |-> host_data_out[6] == !panel.seg_reverse) else $error("Direction flag is wrong.");
   static_on_a: assert property (panel.static_drive |-> panel.display_on && panel.all_com_select)
      else $error("Static drive without display on and all commons.");
   seg_load_a: assert property (cmd_go && host.data[7:1] == 7'h50
      |=> panel.seg_reverse == $past(host.data[0])) else $error("Direction command not applied.");
   start_load_a: assert property (cmd_go && host.data[7:5] == 3'b110
      |=> panel.start_line == $past(host.data[4:0])) else $error("Start line not loaded.");
   duty_load_a: assert property (cmd_go && host.data[7:1] == 7'h54
      |=> panel.duty_32 == $past(host.data[0])) else $error("Duty command not applied.");
   scan_hold_a: assert property (!scan_req |=> $stable(scan_data))
      else $error("Scan data changed without a scan request.");
   scan_limit_a: assert property (ce && scan_req && scan_col >= 7'h50 |=> scan_data == 8'h00)
      else $error("Scan beyond the last column is not zero.");
endmodule
`default_nettype wire

// ---- testbench/lcdc_host_model.sv ----
// Host processor model driving the parallel command and data bus.
`timescale 1ns/1ps
`default_nettype none
module lcdc_host_model
   import lcdc_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] host_data_out,
   output var lcdc_host_pins_t host
);
   initial begin
      host = '0;
   end
   // One bus cycle; the device captures it as the strobe falls.
   task automatic xfer(input logic rs, input logic rnw, input logic [7:0] wd,
      output logic [7:0] rd);
      @(negedge core_clk);
      host.register_select = rs;
      host.read_not_write = rnw;
      host.data = rnw ? ~host.data : wd;
      host.enable = 1'b1;
      repeat (3) @(negedge core_clk);
      rd = host_data_out;
      host.enable = 1'b0;
      @(negedge core_clk);
      // A released bus shows the inverse of its last value, never a settled level.
      host.data = ~host.data;
      repeat (4) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the display command decoder.
`timescale 1ns/1ps
`default_nettype none
module tb import lcdc_pkg::*;;
   logic core_clk, nrst, ce, scan_req, host_data_oe;
   logic [1:0] scan_page;
   logic [6:0] scan_col;
   logic [7:0] host_data_out, scan_data;
   lcdc_host_pins_t host;
   lcdc_panel_t panel;
   int n_mismatch = 0;
   int tests_run = 0;

   lcdc_decoder lcdc_decoder_inst (.core_clk(core_clk), .nrst(nrst), .ce(ce), .host(host),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe), .scan_req(scan_req),
      .scan_page(scan_page), .scan_col(scan_col), .scan_data(scan_data), .panel(panel));
   lcdc_host_model lcdc_host_model_inst (.core_clk(core_clk), .host_data_out(host_data_out),
      .host(host));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic finish_test();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////
   task automatic cmd(input logic [7:0] c);
      logic [7:0] r;
      lcdc_host_model_inst.xfer(1'b0, 1'b0, c, r);
   endtask
   task automatic wr(input logic [7:0] d);
      logic [7:0] r;
      lcdc_host_model_inst.xfer(1'b1, 1'b0, d, r);
   endtask
   task automatic skip_rd();
      logic [7:0] r;
      lcdc_host_model_inst.xfer(1'b1, 1'b1, 8'h00, r);
   endtask
   task automatic rd_chk(input logic [7:0] exp);
      logic [7:0] r;
      lcdc_host_model_inst.xfer(1'b1, 1'b1, 8'h00, r);
      check(r, exp);
   endtask
   task automatic st_chk(input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] r;
      lcdc_host_model_inst.xfer(1'b0, 1'b1, 8'h00, r);
      check(r & mask, exp);
   endtask
   task automatic scan_chk(input logic [1:0] p, input logic [6:0] c, input logic [7:0] exp);
      @(negedge core_clk);
      scan_req = 1'b1;
      scan_page = p;
      scan_col = c;
      @(negedge core_clk);
      scan_req = 1'b0;
      check(scan_data, exp);
   endtask
   task automatic wait_ready();
      logic [7:0] r;
      for (int i = 0; i < 100; i++) begin
         lcdc_host_model_inst.xfer(1'b0, 1'b1, 8'h00, r);
         if (r[7] === 1'b0) return;
      end
      check(r, 8'h00);
   endtask

   ////////////////////////////////////////
   task automatic t_reset();
      repeat (3) @(negedge core_clk);
      st_chk(8'h90, 8'h90);
      wait_ready();
      st_chk(8'hFF, 8'h60);
   endtask

   task automatic t_pages();
      for (int p = 0; p < 4; p++) begin
         cmd({6'b101110, 2'(p)});
         cmd(8'h00);
         wr({6'h30, 2'(p)});
      end
      for (int p = 0; p < 4; p++) begin
         scan_chk(2'(p), 7'h00, {6'h30, 2'(p)});
      end
      cmd(8'hB9);
      cmd(8'h4E);
      wr(8'hA1);
      wr(8'hA2);
      wr(8'hA3);
      cmd(8'hB8);
      scan_chk(2'h1, 7'h4E, 8'hA1);
      scan_chk(2'h1, 7'h4F, 8'hA2);
      scan_chk(2'h2, 7'h00, 8'hC2);
      scan_chk(2'h2, 7'h50, 8'h00);
      cmd(8'hB9);
      cmd(8'h4E);
      skip_rd();
      rd_chk(8'hA1);
      rd_chk(8'hA2);
      rd_chk(8'h00);
   endtask

   task automatic t_panel();
      logic b;
      for (int i = 0; i < 2; i++) begin
         b = i[0];
         cmd({7'h57, b});
         cmd({7'h50, b});
         cmd({7'h54, b});
         check({7'h00, panel.display_on}, {7'h00, b});
         check({7'h00, panel.seg_reverse}, {7'h00, b});
         check({7'h00, panel.duty_32}, {7'h00, b});
         st_chk(8'h60, {1'b0, ~b, ~b, 5'h00});
      end
      cmd(8'hAE);
      cmd(8'hA5);
      check({5'h00, panel.display_on, panel.static_drive, panel.all_com_select}, 8'h07);
      cmd(8'hA4);
      check({5'h00, panel.display_on, panel.static_drive, panel.all_com_select}, 8'h00);
      cmd(8'hD5);
      check({3'h0, panel.start_line}, 8'h15);
   endtask

   // With the clock enable low the strobe edge is never seen, so the command is lost.
   task automatic t_ce();
      ce = 1'b0;
      cmd(8'hDF);
      ce = 1'b1;
      check({3'h0, panel.start_line}, 8'h15);
   endtask

   task automatic t_rmw();
      cmd(8'hB8);
      cmd(8'h0A);
      wr(8'h55);
      wr(8'h66);
      cmd(8'h0A);
      cmd(8'hE0);
      skip_rd();
      rd_chk(8'h55);
      rd_chk(8'h55);
      cmd(8'hC3);
      check({3'h0, panel.start_line}, 8'h03);
      wr(8'h77);
      wr(8'h88);
      cmd(8'hEE);
      skip_rd();
      rd_chk(8'h77);
      rd_chk(8'h88);
   endtask

   task automatic t_swrst();
      cmd(8'hE2);
      st_chk(8'h90, 8'h90);
      cmd(8'hC7);
      wait_ready();
      check({3'h0, panel.start_line}, 8'h00);
      cmd(8'h20);
      wr(8'hE5);
      scan_chk(2'h3, 7'h20, 8'hE5);
      scan_chk(2'h1, 7'h4E, 8'hA1);
   endtask

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      scan_req = 1'b0;
      scan_page = 2'h0;
      scan_col = 7'h00;
      repeat (8) @(negedge core_clk);
      nrst = 1'b1;
      t_reset();
      t_pages();
      t_panel();
      t_ce();
      t_rmw();
      t_swrst();
      finish_test();
   end

   // The whole run needs some 1100 cycles; this cuts a hang short.
   initial begin
      repeat (8000) @(posedge core_clk);
      check(8'h00, 8'hFF);
      finish_test();
   end
endmodule

bind lcdc_decoder lcdc_decoder_properties lcdc_decoder_properties_inst (.core_clk(core_clk),
   .nrst(nrst), .ce(ce), .host(host), .host_data_out(host_data_out),
   .host_data_oe(host_data_oe), .scan_req(scan_req), .scan_page(scan_page),
   .scan_col(scan_col), .scan_data(scan_data), .panel(panel));
`default_nettype wire
